// File: core/pxr_adc_lane.sv
/*
 package of shared constants for the pixel readout path, and one converter lane.
 assumes the conversion clock is a plain synchronous input whose falling edge
 the top module detects and hands to each lane as a one-cycle strobe.
*/

package pxr_pkg;
    // converter word width
    localparam int unsigned WORD_W = 10;
    // number of converter lanes: even columns, odd columns
    localparam int unsigned LANES = 2;
    // lane index of the even-column converter
    localparam int unsigned LANE_EVEN = 0;
    // lane index of the odd-column converter
    localparam int unsigned LANE_ODD = 1;
    // falling edges from sampling to output word
    localparam int unsigned PIPE_DEPTH = 2;
    // lines in the pixel array
    localparam int unsigned LINES = 2048;
    // width of the line address
    localparam int unsigned LINE_W = 11;
    // last line address
    localparam logic [10:0] LINE_LAST = 11'h7FF;
    // line address after reset
    localparam logic [10:0] LINE_RST = 11'h000;
    // word value after reset
    localparam logic [9:0] WORD_RST = 10'h000;
    // system clock rate in hertz
    localparam int unsigned CLK_HZ = 20000000;
    // nominal converter rate in samples per second
    localparam int unsigned ADC_NOM_SPS = 10000000;
    // least system cycles per conversion clock period
    localparam int unsigned ADC_PERIOD_CLKS = (CLK_HZ + ADC_NOM_SPS - 1) / ADC_NOM_SPS;
endpackage : pxr_pkg

`timescale 1ns/1ps

module pxr_adc_lane (
    input wire logic clk, // system clock
    input wire logic nrst, // async reset, active low
    input wire logic convFall, // falling edge of the conversion clock
    input wire logic [9:0] ampIn, // level presented at the converter input
    output logic [9:0] wordOut // converted word, from a flip-flop
);
    // whole lane state
    typedef struct packed {
        logic [9:0] stage1; // word taken at the sampling edge
        logic [9:0] word; // word at the output
    } pxr_lane_t;

    pxr_lane_t cur_ff; // registered state
    pxr_lane_t nxt_cur; // next state

    // two-stage pipeline stepped on falling conversion edges
    always_comb begin
        nxt_cur = cur_ff;
        if (convFall) begin
            nxt_cur.stage1 = ampIn;
            nxt_cur.word = cur_ff.stage1;
        end
    end

    // state register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cur_ff <= '{stage1: pxr_pkg::WORD_RST, word: pxr_pkg::WORD_RST};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign wordOut = cur_ff.word;

    // output holds between conversion edges
    a_lane_hold: assert property (@(posedge clk) disable iff (!nrst)
        !convFall |=> $stable(wordOut))
        else $error("converter word changed without a conversion edge");
endmodule : pxr_adc_lane

// File: core/pxr_readout.sv
/*
 pixel readout path: column amplifier with pair averaging, even/odd split onto
 two converter lanes, and the snapshot shutter sequencer with repeat reads.
 assumes all inputs are synchronous to clk and that the camera controller
 drives the conversion clock no faster than half the system clock.
*/

`timescale 1ns/1ps

module pxr_readout (
    input wire logic clk, // system clock, 20 MHz
    input wire logic nrst, // async reset, active low
    input wire logic convClk, // conversion clock from the controller
    input wire logic colValid, // column level valid this cycle
    input wire logic colOdd, // column number is odd
    input wire logic [9:0] colLevel, // column amplifier level
    input wire logic avgPin, // external averaging request
    input wire logic avgCfg, // serial-port averaging bit
    input wire logic overlapMode, // allow integration during readout
    input wire logic repeatReadMode, // non-destructive repeated reads
    input wire logic frameStart, // pulse: begin integration
    input wire logic frameEnd, // pulse: end integration
    input wire logic lineNext, // pulse: step to next line
    output logic [9:0] evenWord, // even-column converter word
    output logic [9:0] oddWord, // odd-column converter word
    output logic avgActive, // averaging in force
    output logic pixReset, // pulse: global pixel reset
    output logic pixSample, // pulse: global sample to storage
    output logic integActive, // integration in progress
    output logic readActive, // line readout in progress
    output logic [10:0] lineAddr // line being read
);
    // readout sequencer states
    typedef enum logic {
        RD_IDLE, // no frame being read
        RD_LINES // lines being read
    } pxr_rd_t;

    // whole state of the block
    typedef struct packed {
        logic convPrev; // conversion clock one cycle ago
        logic [9:0] ampEven; // level held for the even lane
        logic [9:0] ampOdd; // level held for the odd lane
        logic [9:0] pairFirst; // first column of an averaging pair
        logic avgOn; // averaging in force
        logic reset; // global reset pulse
        logic sample; // global sample pulse
        logic integ; // integration running
        logic pendSample; // end of integration waiting for readout
        logic ndrHeld; // array reset once for repeat reads
        pxr_rd_t rd; // readout state
        logic [10:0] line; // line address
    } pxr_state_t;

    pxr_state_t cur_ff; // registered state
    pxr_state_t nxt_cur; // next state
    logic convFall; // falling edge of conversion clock
    logic [10:0] pairSum; // sum of a column pair
    logic canStart; // integration start is allowed
    logic [9:0] laneIn [pxr_pkg::LANES]; // per-lane converter input
    logic [9:0] laneOut [pxr_pkg::LANES]; // per-lane converter word

    // edge of the conversion clock
    assign convFall = cur_ff.convPrev & ~convClk;
    // pair sum for averaging
    assign pairSum = {1'b0, cur_ff.pairFirst} + {1'b0, colLevel};
    // start allowed when not integrating and no sample pending, with readout idle or overlapping
    assign canStart = !cur_ff.integ && !cur_ff.pendSample
        && (overlapMode || cur_ff.rd == RD_IDLE);

    // next-state logic
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.convPrev = convClk;
        nxt_cur.reset = 1'b0;
        nxt_cur.sample = 1'b0;
        nxt_cur.avgOn = avgPin & avgCfg;
        // column amplifier: route or average
        if (colValid) begin
            if (cur_ff.avgOn) begin
                if (!colOdd) begin
                    nxt_cur.pairFirst = colLevel; // hold first of the pair
                end else begin
                    nxt_cur.ampEven = pairSum[10:1];
                end
            end else if (!colOdd) begin
                nxt_cur.ampEven = colLevel;
            end else begin
                nxt_cur.ampOdd = colLevel;
            end
        end
        // repeat-read hold clears when the mode is left
        if (!repeatReadMode) begin
            nxt_cur.ndrHeld = 1'b0;
        end
        // integration start: global reset unless repeat reads hold charge
        if (frameStart && canStart) begin
            nxt_cur.integ = 1'b1;
            if (!(repeatReadMode && cur_ff.ndrHeld)) begin
                nxt_cur.reset = 1'b1;
            end
            if (repeatReadMode) begin
                nxt_cur.ndrHeld = 1'b1;
            end
        end
        // end of integration waits for storage nodes to be free
        if (frameEnd && cur_ff.integ) begin
            nxt_cur.integ = 1'b0;
            nxt_cur.pendSample = 1'b1;
        end
        // readout sequencer
        unique case (cur_ff.rd)
            RD_IDLE: begin
                if (cur_ff.pendSample) begin
                    nxt_cur.sample = 1'b1;
                    nxt_cur.pendSample = 1'b0;
                    nxt_cur.rd = RD_LINES;
                    nxt_cur.line = pxr_pkg::LINE_RST;
                end
            end
            RD_LINES: begin
                if (lineNext) begin
                    if (cur_ff.line == pxr_pkg::LINE_LAST) begin
                        nxt_cur.rd = RD_IDLE; // frame done
                    end else begin
                        nxt_cur.line = cur_ff.line + 11'h001;
                    end
                end
            end
        endcase
    end

    // state register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cur_ff <= '{convPrev: 1'b0, ampEven: pxr_pkg::WORD_RST,
                ampOdd: pxr_pkg::WORD_RST, pairFirst: pxr_pkg::WORD_RST,
                avgOn: 1'b0, reset: 1'b0, sample: 1'b0, integ: 1'b0,
                pendSample: 1'b0, ndrHeld: 1'b0, rd: RD_IDLE,
                line: pxr_pkg::LINE_RST};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // lane inputs
    assign laneIn[pxr_pkg::LANE_EVEN] = cur_ff.ampEven;
    assign laneIn[pxr_pkg::LANE_ODD] = cur_ff.ampOdd;

    // two converter lanes
    generate
        for (genvar g = 0; g < pxr_pkg::LANES; g++) begin : gLane
            pxr_adc_lane uLane (
                .clk(clk),
                .nrst(nrst),
                .convFall(convFall),
                .ampIn(laneIn[g]),
                .wordOut(laneOut[g])
            );
        end
    endgenerate

    // outputs straight from flip-flops
    assign evenWord = laneOut[pxr_pkg::LANE_EVEN];
    assign oddWord = laneOut[pxr_pkg::LANE_ODD];
    assign avgActive = cur_ff.avgOn;
    assign pixReset = cur_ff.reset;
    assign pixSample = cur_ff.sample;
    assign integActive = cur_ff.integ;
    assign readActive = (cur_ff.rd == RD_LINES);
    assign lineAddr = cur_ff.line;

    // helper: level sampled at the last conversion edge
    logic [9:0] chkSampled_ff; // even level at last falling edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            chkSampled_ff <= pxr_pkg::WORD_RST;
        end else if (convFall) begin
            chkSampled_ff <= cur_ff.ampEven;
        end
    end

    // helper: odd level sampled at the last conversion edge
    logic [9:0] chkOddSampled_ff; // odd level at last falling edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            chkOddSampled_ff <= pxr_pkg::WORD_RST; // cleared
        end else if (convFall) begin
            chkOddSampled_ff <= cur_ff.ampOdd; // odd level taken
        end
    end

    default clocking cbMain @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // even level sampled, word appears at next edge (two edges total)
    a_pipe_latency: assert property (
        convFall |=> evenWord == $past(chkSampled_ff))
        else $error("converter word not two conversion edges late");
    // even column goes to the even lane
    a_even_route: assert property (
        colValid && !colOdd && !cur_ff.avgOn |=> cur_ff.ampEven == $past(colLevel))
        else $error("even column not routed to even lane");
    // odd column goes to the odd lane, even lane untouched
    a_odd_route: assert property (
        colValid && colOdd && !cur_ff.avgOn
        |=> cur_ff.ampOdd == $past(colLevel) && $stable(cur_ff.ampEven))
        else $error("odd column not routed to odd lane");
    // averaged pair gives the mean
    a_avg_mean: assert property (
        colValid && !colOdd && cur_ff.avgOn ##1 colValid && colOdd && cur_ff.avgOn
        |=> cur_ff.ampEven == 10'(({1'b0, $past(colLevel, 2)} + {1'b0, $past(colLevel)}) >> 1))
        else $error("averaged value is not the pair mean");
    // averaging needs both pin and bit
    a_avg_gate: assert property (
        ##1 avgActive == $past(avgPin && avgCfg))
        else $error("averaging state disagrees with pin and bit");
    // accepted start resets the array unless repeat reads hold it
    a_global_reset: assert property (
        frameStart && canStart && !repeatReadMode |=> pixReset ##1 !pixReset)
        else $error("global reset missing or too long");
    // sample opens a readout from line zero
    a_sample_read: assert property (
        pixSample |-> readActive && lineAddr == pxr_pkg::LINE_RST)
        else $error("global sample without readout start");
    // one line step per request
    a_line_step: assert property (
        readActive && lineNext && lineAddr != pxr_pkg::LINE_LAST
        |=> lineAddr == $past(lineAddr) + 11'h001)
        else $error("line address did not step by one");
    // repeat reads never reset a held array
    a_ndr_noreset: assert property (
        repeatReadMode && cur_ff.ndrHeld |=> !pixReset)
        else $error("array reset during repeat reads");
    // no start while reading unless overlapping
    a_no_overlap: assert property (
        readActive && !overlapMode && frameStart |=> !pixReset)
        else $error("integration started during readout without overlap");

    // further guards on the odd lane, averaging and sequencing
    // odd level sampled, word appears at next edge (two edges total)
    a_odd_latency: assert property (
        convFall |=> oddWord == $past(chkOddSampled_ff))
        else $error("odd converter word not two conversion edges late");
    // averaging leaves the odd lane alone
    a_avg_odd_keep: assert property (
        colValid && cur_ff.avgOn |=> $stable(cur_ff.ampOdd))
        else $error("odd lane level moved while averaging");
    // first column of a pair is held back while averaging
    a_avg_hold: assert property (
        colValid && !colOdd && cur_ff.avgOn |=> $stable(cur_ff.ampEven))
        else $error("even lane level moved on the first column of a pair");
    // accepted start raises integration at the next edge
    a_integ_start: assert property (
        frameStart && canStart |=> integActive)
        else $error("integration did not start on an accepted request");
    // refused start leaves integration and the array alone
    a_start_refused: assert property (
        frameStart && !canStart && !frameEnd |=> $stable(integActive) && !pixReset)
        else $error("refused start changed integration state");
    // first start in repeat reads still resets the array
    a_ndr_first: assert property (
        frameStart && canStart && repeatReadMode && !cur_ff.ndrHeld |=> pixReset)
        else $error("first repeat-read frame missed its global reset");
    // end of integration stops it at the next edge
    a_integ_end: assert property (
        frameEnd && integActive |=> !integActive)
        else $error("integration still running after its end request");
    // global sample is a single-cycle pulse
    a_sample_pulse: assert property (
        pixSample |=> !pixSample)
        else $error("global sample longer than one cycle");
    // line address holds without a step request
    a_line_hold: assert property (
        readActive && !lineNext |=> $stable(lineAddr))
        else $error("line address moved without a step request");
    // step on the last line ends the readout
    a_read_done: assert property (
        readActive && lineNext && lineAddr == pxr_pkg::LINE_LAST |=> !readActive)
        else $error("readout did not end after the last line");

    // scenario coverage
    c_frame: cover property (pixReset ##[1:1000] pixSample);
    c_overlap: cover property (readActive && pixReset);
    c_avg: cover property (avgActive && colValid && colOdd);
    c_ndr: cover property (repeatReadMode && cur_ff.ndrHeld && pixSample);
    c_last_line: cover property (readActive && lineNext && lineAddr == pxr_pkg::LINE_LAST);
endmodule : pxr_readout

// File: tb/pxr_ctrl_model.sv
/*
 camera controller model: makes the conversion clock and captures words.
 assumes the bench drives convRun on the falling clk edge.
*/
`timescale 1ns/1ps
module pxr_ctrl_model (
    input wire logic clk, // system clock
    input wire logic nrst, // async reset, active low
    input wire logic convRun, // run the conversion clock
    input wire logic [9:0] evenWord, // even lane word
    input wire logic [9:0] oddWord, // odd lane word
    output logic convClk, // conversion clock, idle high
    output logic [9:0] capEven, // captured even word
    output logic [9:0] capOdd // captured odd word
);
    // toggle every clk: two clk periods, nominal converter rate
    always @(negedge clk or negedge nrst) begin
        if (!nrst) begin
            convClk <= 1'b1; // idle level
        end else if (convRun) begin
            convClk <= ~convClk;
        end else begin
            convClk <= 1'b1; // stands still between bursts
        end
    end
    // capture on the rise, past the latency point; keeps each read
    always @(posedge convClk or negedge nrst) begin
        if (!nrst) begin
            capEven <= 10'h000; // cleared
            capOdd <= 10'h000; // cleared
        end else begin
            capEven <= evenWord;
            capOdd <= oddWord;
        end
    end
endmodule : pxr_ctrl_model

// File: tb/pxr_readout_test.sv
/*
 self-checking bench for the pixel readout path.
 assumes pxr_ctrl_model and the core files are compiled first.
*/
`timescale 1ns/1ps
module pxr_readout_test;
    logic clk = 1'b0; // system clock
    logic nrst = 1'b0; // reset, active low
    logic convRun = 1'b0; // conversion burst request
    logic colValid = 1'b0; // column strobe
    logic colOdd = 1'b0; // odd column
    logic [9:0] colLevel = 10'h000; // column level
    logic avgPin = 1'b0; // averaging pin
    logic avgCfg = 1'b0; // averaging bit
    logic overlapMode = 1'b0; // overlap integration
    logic repeatReadMode = 1'b0; // repeat reads
    logic frameStart = 1'b0; // start pulse
    logic frameEnd = 1'b0; // end pulse
    logic lineNext = 1'b0; // line step
    logic convClk; // from model
    logic [9:0] evenWord; // even lane
    logic [9:0] oddWord; // odd lane
    logic [9:0] capEven; // captured even
    logic [9:0] capOdd; // captured odd
    logic avgActive; // averaging flag
    logic pixReset; // reset pulse
    logic pixSample; // sample pulse
    logic integActive; // integrating
    logic readActive; // reading
    logic [10:0] lineAddr; // line
    logic [10:0] nr; // reset pulse count
    logic [10:0] ns; // sample pulse count
    int errors = 0; // mismatches
    int n_tests = 0; // comparisons
    int cycles = 0; // run length
    localparam int MaxCycles = 40000; // ceiling for the run
    pxr_readout DUT (.clk(clk), .nrst(nrst), .convClk(convClk), .colValid(colValid),
        .colOdd(colOdd), .colLevel(colLevel), .avgPin(avgPin), .avgCfg(avgCfg),
        .overlapMode(overlapMode), .repeatReadMode(repeatReadMode), .frameStart(frameStart),
        .frameEnd(frameEnd), .lineNext(lineNext), .evenWord(evenWord), .oddWord(oddWord),
        .avgActive(avgActive), .pixReset(pixReset), .pixSample(pixSample),
        .integActive(integActive), .readActive(readActive), .lineAddr(lineAddr));
    pxr_ctrl_model ctrl (.clk(clk), .nrst(nrst), .convRun(convRun), .evenWord(evenWord),
        .oddWord(oddWord), .convClk(convClk), .capEven(capEven), .capOdd(capOdd));
    // free-running clock, 50 ns
    always #25 clk = ~clk;
    // compare and report
    task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // counts, verdict, stop
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up
    // n conversion falls, then let the pipeline settle
    task automatic falls(input int n);
        convRun <= 1'b1;
        repeat (n) @(negedge convClk);
        @(negedge clk);
        convRun <= 1'b0;
        repeat (3) @(negedge clk);
    endtask : falls
    // present one column level; caller drops the strobe
    task automatic column(input logic odd, input logic [9:0] lvl);
        colValid = 1'b1;
        colOdd = odd;
        colLevel = lvl;
        @(negedge clk);
    endtask : column
    // one-cycle pulse on start, end or step, then count global pulses over six cycles
    task automatic fire(input logic st, input logic en, input logic ln);
        frameStart = st;
        frameEnd = en;
        lineNext = ln;
        @(negedge clk);
        frameStart = 1'b0;
        frameEnd = 1'b0;
        lineNext = 1'b0;
        nr = 11'h000;
        ns = 11'h000;
        repeat (6) begin
            nr = nr + {10'h000, pixReset};
            ns = ns + {10'h000, pixSample};
            @(negedge clk);
        end
    endtask : fire
    // step through n lines
    task automatic lines(input int n);
        repeat (n) begin
            lineNext = 1'b1;
            @(negedge clk);
            lineNext = 1'b0;
            @(negedge clk);
        end
    endtask : lines
    // even and odd lanes with two-fall latency
    task automatic t_lanes;
        column(1'b0, 10'h2A5);
        column(1'b1, 10'h15A);
        colValid = 1'b0;
        @(negedge clk);
        falls(1);
        check("evenWord early", {1'b0, evenWord}, 11'h000);
        falls(1);
        check("evenWord", {1'b0, evenWord}, 11'h2A5);
        check("oddWord", {1'b0, oddWord}, 11'h15A);
        falls(1);
        check("capEven", {1'b0, capEven}, 11'h2A5);
        check("capOdd", {1'b0, capOdd}, 11'h15A);
    endtask : t_lanes
    // averaging needs both controls; mean to even lane
    task automatic t_avg;
        avgPin = 1'b1;
        @(negedge clk);
        check("avgActive pin", {10'h000, avgActive}, 11'h000);
        avgPin = 1'b0;
        avgCfg = 1'b1;
        @(negedge clk);
        check("avgActive cfg", {10'h000, avgActive}, 11'h000);
        avgPin = 1'b1;
        @(negedge clk);
        check("avgActive both", {10'h000, avgActive}, 11'h001);
        column(1'b0, 10'h100);
        column(1'b1, 10'h203);
        colValid = 1'b0;
        @(negedge clk);
        falls(2);
        check("evenWord mean", {1'b0, evenWord}, 11'h181);
        check("oddWord kept", {1'b0, oddWord}, 11'h15A);
        avgPin = 1'b0;
        avgCfg = 1'b0;
    endtask : t_avg
    // global reset, sample, line readout, overlap
    task automatic t_shutter;
        fire(1'b1, 1'b0, 1'b0); // start
        check("pixReset", nr, 11'h001);
        check("integActive", {10'h000, integActive}, 11'h001);
        fire(1'b0, 1'b1, 1'b0); // end
        check("pixSample", ns, 11'h001);
        check("readActive", {10'h000, readActive}, 11'h001);
        check("lineAddr", lineAddr, 11'h000);
        fire(1'b1, 1'b0, 1'b0); // start while reading
        check("start refused", {10'h000, integActive}, 11'h000);
        overlapMode = 1'b1;
        fire(1'b1, 1'b0, 1'b0); // start, overlapping
        check("overlap reset", nr, 11'h001);
        fire(1'b0, 1'b1, 1'b0); // end
        check("sample held", ns, 11'h000);
        lines(2047);
        check("last line", lineAddr, 11'h7FF);
        fire(1'b0, 1'b0, 1'b1); // last step
        check("late sample", ns, 11'h001);
        check("line restart", lineAddr, 11'h000);
        lines(2047);
        fire(1'b0, 1'b0, 1'b1); // last step
        check("read done", {10'h000, readActive}, 11'h000);
        overlapMode = 1'b0;
    endtask : t_shutter
    // repeat reads: one reset, two frames
    task automatic t_repeat;
        repeatReadMode = 1'b1;
        fire(1'b1, 1'b0, 1'b0); // start
        check("first reset", nr, 11'h001);
        fire(1'b0, 1'b1, 1'b0); // end
        lines(2047);
        fire(1'b0, 1'b0, 1'b1); // last step
        fire(1'b1, 1'b0, 1'b0); // start again
        check("no reset", nr, 11'h000);
        check("integ again", {10'h000, integActive}, 11'h001);
        fire(1'b0, 1'b1, 1'b0); // end
        check("resample", ns, 11'h001);
        repeatReadMode = 1'b0;
    endtask : t_repeat
    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == MaxCycles) begin
            errors++;
            wrap_up();
        end
    end
    // main sequence
    initial begin
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        t_lanes();
        t_avg();
        t_shutter();
        t_repeat();
        wrap_up();
    end
endmodule : pxr_readout_test
